/* File: design/uff_consts.svh */
// Constants of the serial FIFO control and DMA-ready block.
// Assumes a 250 MHz core clock and a byte-addressed Avalon-MM bus.
// Behaviour
// - Receive-data interrupt asserts at trigger count, drops below it.
// - Cause register shows trigger reached, cleared with the interrupt.
// - Data-ready bit set on first stored byte, cleared when empty.
// - Enabled FIFOs with all four interrupt enables clear means polled mode.
// - Status bit 5 means transmit FIFO empty, bit 6 also shifter empty.
// - Status bits 1-4 give receive error kinds, bit 7 any FIFO error.
// - Mode 0 transmit ready low while empty, high after first load.
// - Mode 0 receive ready low while data held, high when empty.
// - Mode 1 transmit ready high when full, low at trigger level.
// - Mode 1 receive ready low at trigger or timeout, high when empty.
// - Mode 1 transmit interrupt below trigger, receive at trigger.
// - Receive FIFO keeps filling past trigger until full.
// - Two-bit field picks receive trigger level.
// - Depth bit selects 16 bytes when zero, 64 bytes when one.
// - DMA bit selects mode 0 or 1; bit 4 reserved.
// - Transmit clear empties FIFO, leaves shifter, self-clears.
// - Receive clear empties FIFO, leaves shifter, self-clears.
// - Enable bit turns both FIFOs on; off means single holding byte.
// - Trigger codes give 1,4,8,14 or 1,16,32,56 bytes.
`ifndef UFF_CONSTS_SVH
`define UFF_CONSTS_SVH
// =====================================================
// Register byte offsets
`define UFF_OFF_DATA 5'h00
`define UFF_OFF_MASK 5'h04
`define UFF_OFF_SETUP 5'h08
`define UFF_OFF_CAUSE 5'h0c
`define UFF_OFF_LINE 5'h10
`define UFF_OFF_TXTRIG 5'h14
// =====================================================
// Reset values
`define UFF_SETUP_RST 8'h00
`define UFF_MASK_RST 4'h0
`define UFF_TXTRIG_RST 7'h08
// =====================================================
// Depths and trigger levels
`define UFF_DEPTH_SHALLOW 7'd16
`define UFF_DEPTH_DEEP 7'd64
`define UFF_DEPTH_SINGLE 7'd1
`define UFF_TRIG_S0 7'd1
`define UFF_TRIG_S1 7'd4
`define UFF_TRIG_S2 7'd8
`define UFF_TRIG_S3 7'd14
`define UFF_TRIG_D0 7'd1
`define UFF_TRIG_D1 7'd16
`define UFF_TRIG_D2 7'd32
`define UFF_TRIG_D3 7'd56
// =====================================================
// Cause codes, bits 3:0
`define UFF_CAUSE_NONE 4'h1
`define UFF_CAUSE_RXLVL 4'h4
`define UFF_CAUSE_RXTO 4'hc
`define UFF_CAUSE_TX 4'h2
`endif

/* File: design/uff_pkg.sv */
// Types of the serial FIFO control and DMA-ready block.
// Assumes uff_consts.svh supplies the numbers.
package uff_pkg;
    // Layout of the FIFO setup register
    typedef struct packed {
        logic [1:0] rx_trigger_field;
        logic deep;
        logic rsvd;
        logic dma_mode;
        logic tx_fifo_clear;
        logic rx_fifo_clear;
        logic fifo_en;
    } uff_setup_t;
    // One stored receive character with its error kinds
    typedef struct packed {
        logic brk;
        logic framing;
        logic parity;
        logic data_err_unused;
        logic [7:0] data;
    } uff_rx_word_t;
endpackage

/* File: design/uff_top.sv */
// FIFO control, status and DMA-ready logic of a serial controller.
// Assumes shift registers and time-out detect on the same core clock.
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "uff_consts.svh"
module uff_top import uff_pkg::*; #(
    parameter int ADDR_W = 5
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic RX_PUSH,
    input wire uff_rx_word_t RX_WORD,
    input wire logic RX_TIMEOUT,
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    input wire logic TX_POP,
    input wire logic TX_SHIFT_BUSY,
    output logic RX_DATA_IRQ,
    output logic TX_IRQ,
    output logic TX_DMA_REQ_N,
    output logic RX_DMA_REQ_N
);
    // =====================================================
    // Helpers
    function automatic logic [6:0] trig_level(input logic [1:0] code,
                                              input logic deep);
        unique case (code)
            2'd0: trig_level = deep ? `UFF_TRIG_D0 : `UFF_TRIG_S0;
            2'd1: trig_level = deep ? `UFF_TRIG_D1 : `UFF_TRIG_S1;
            2'd2: trig_level = deep ? `UFF_TRIG_D2 : `UFF_TRIG_S2;
            2'd3: trig_level = deep ? `UFF_TRIG_D3 : `UFF_TRIG_S3;
        endcase
    endfunction

    function automatic logic sel(input logic [ADDR_W-1:0] a,
                                 input logic [4:0] off);
        sel = (a == ADDR_W'(off));
    endfunction

    // =====================================================
    // Bus slave: one wait state, action at the release edge
    uff_setup_t setup;
    logic [3:0] irq_mask_reg;
    logic [6:0] tx_trig;
    logic done;
    logic req;
    logic wr_go;
    logic rd_go;
    assign req = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~done;
    assign wr_go = AVS_WRITE & done;
    assign rd_go = AVS_READ & done;

    // Done pulses for one cycle to end each request
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            done <= 1'b0;
        end else begin
            done <= req & ~done;
        end
    end

    // =====================================================
    // FIFO storage and counts
    uff_rx_word_t rx_mem [0:63];
    logic [7:0] tx_mem [0:63];
    logic [5:0] rx_wr, rx_rd, tx_wr, tx_rd;
    logic [6:0] rx_cnt, tx_cnt, rx_err_cnt, cap;
    logic rx_full, tx_full, rx_pop, tx_push, rx_in, tx_out;
    logic setup_wr, fifo_on, rx_clr, tx_clr;
    logic [6:0] rx_trig;
    logic overrun, rx_to, polled;
    uff_setup_t wsetup;
    assign wsetup = uff_setup_t'(AVS_WRITEDATA[7:0]);
    assign setup_wr = wr_go & sel(AVS_ADDRESS, `UFF_OFF_SETUP);
    assign fifo_on = setup.fifo_en;
    // Capacity falls to one byte when the FIFOs are off
    assign cap = !fifo_on ? `UFF_DEPTH_SINGLE :
                 setup.deep ? `UFF_DEPTH_DEEP :
                 `UFF_DEPTH_SHALLOW;
    assign rx_trig = trig_level(setup.rx_trigger_field,
                                setup.deep);
    assign rx_full = (rx_cnt >= cap);
    assign tx_full = (tx_cnt >= cap);
    // Clears act at the write edge; toggling enable also flushes
    assign rx_clr = setup_wr & ((wsetup.fifo_en & wsetup.rx_fifo_clear)
                    | (wsetup.fifo_en != fifo_on));
    assign tx_clr = setup_wr & ((wsetup.fifo_en & wsetup.tx_fifo_clear)
                    | (wsetup.fifo_en != fifo_on));
    // Receive keeps loading past the trigger until full
    assign rx_in = RX_PUSH & ~rx_full;
    assign rx_pop = rd_go & sel(AVS_ADDRESS, `UFF_OFF_DATA)
                    & (rx_cnt != 7'd0);
    assign tx_push = wr_go & sel(AVS_ADDRESS, `UFF_OFF_DATA) & ~tx_full;
    assign tx_out = TX_POP & (tx_cnt != 7'd0);
    assign TX_VALID = (tx_cnt != 7'd0);
    assign TX_DATA = tx_mem[tx_rd];

    // Setup register; a write with enable low only disables
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            setup <= uff_setup_t'(`UFF_SETUP_RST);
        end else if (setup_wr) begin
            if (wsetup.fifo_en) begin
                setup <= wsetup;
                setup.tx_fifo_clear <= 1'b0;
                setup.rx_fifo_clear <= 1'b0;
                setup.rsvd <= 1'b0;
            end else begin
                setup.fifo_en <= 1'b0;
            end
        end
    end

    // Interrupt enables and transmit trigger
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            irq_mask_reg <= `UFF_MASK_RST;
            tx_trig <= `UFF_TXTRIG_RST;
        end else if (wr_go) begin
            if (sel(AVS_ADDRESS, `UFF_OFF_MASK)) begin
                irq_mask_reg <= AVS_WRITEDATA[3:0];
            end
            if (sel(AVS_ADDRESS, `UFF_OFF_TXTRIG)) begin
                tx_trig <= AVS_WRITEDATA[6:0];
            end
        end
    end

    // Receive and transmit store; shift register side is never touched by a clear
    always_ff @(posedge CORE_CLK) begin
        if (rx_in) begin
            rx_mem[rx_wr] <= RX_WORD;
        end
        if (tx_push) begin
            tx_mem[tx_wr] <= AVS_WRITEDATA[7:0];
        end
    end

    // Receive pointers and counts
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            rx_wr <= 6'd0;
            rx_rd <= 6'd0;
            rx_cnt <= 7'd0;
            rx_err_cnt <= 7'd0;
        end else if (rx_clr) begin
            rx_wr <= 6'd0;
            rx_rd <= 6'd0;
            rx_cnt <= 7'd0;
            rx_err_cnt <= 7'd0;
        end else begin
            if (rx_in) begin
                rx_wr <= rx_wr + 6'd1;
            end
            if (rx_pop) begin
                rx_rd <= rx_rd + 6'd1;
            end
            rx_cnt <= rx_cnt + 7'(rx_in) - 7'(rx_pop);
            rx_err_cnt <= rx_err_cnt
                + 7'(rx_in & |RX_WORD[11:9])
                - 7'(rx_pop & |rx_mem[rx_rd][11:9]);
        end
    end

    // Transmit pointers and count
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            tx_wr <= 6'd0;
            tx_rd <= 6'd0;
            tx_cnt <= 7'd0;
        end else if (tx_clr) begin
            tx_wr <= 6'd0;
            tx_rd <= 6'd0;
            tx_cnt <= 7'd0;
        end else begin
            if (tx_push) begin
                tx_wr <= tx_wr + 6'd1;
            end
            if (tx_out) begin
                tx_rd <= tx_rd + 6'd1;
            end
            tx_cnt <= tx_cnt + 7'(tx_push) - 7'(tx_out);
        end
    end

    // =====================================================
    // Sticky receive events; a new event beats the clear
    logic line_rd;
    assign line_rd = rd_go & sel(AVS_ADDRESS, `UFF_OFF_LINE);
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            overrun <= 1'b0;
            rx_to <= 1'b0;
        end else begin
            if (RX_PUSH & rx_full) begin
                overrun <= 1'b1;
            end else if (line_rd) begin
                overrun <= 1'b0;
            end
            if (RX_TIMEOUT & fifo_on) begin
                rx_to <= 1'b1;
            end else if (rx_pop | rx_clr | rx_cnt == 7'd0) begin
                rx_to <= 1'b0;
            end
        end
    end

    // =====================================================
    // Interrupt levels and cause
    logic rx_lvl, rx_irq_i, tx_irq_i;
    logic [3:0] cause;
    assign polled = fifo_on & (irq_mask_reg == 4'h0);
    assign rx_lvl = fifo_on ? (rx_cnt >= rx_trig)
                            : (rx_cnt != 7'd0);
    assign rx_irq_i = irq_mask_reg[0] & rx_lvl;
    assign tx_irq_i = irq_mask_reg[1] &
        ((fifo_on & setup.dma_mode) ? (tx_cnt < tx_trig)
                                    : (tx_cnt == 7'd0));
    assign RX_DATA_IRQ = rx_irq_i | (irq_mask_reg[0] & rx_to);
    assign TX_IRQ = tx_irq_i;
    // Receive level outranks time-out, which outranks transmit
    always_comb begin
        if (rx_irq_i) begin
            cause = `UFF_CAUSE_RXLVL;
        end else if (irq_mask_reg[0] & rx_to) begin
            cause = `UFF_CAUSE_RXTO;
        end else if (tx_irq_i) begin
            cause = `UFF_CAUSE_TX;
        end else begin
            cause = `UFF_CAUSE_NONE;
        end
    end

    // =====================================================
    // DMA ready pins; mode 1 keeps state between the two thresholds.
    // The pins follow the counts at once and the flops only remember
    // the hysteresis, so a DMA engine never acts on a level a cycle old.
    logic tx_hold, rx_hold, mode1, tx_blk, rx_blk;
    assign mode1 = fifo_on & setup.dma_mode;
    assign tx_blk = tx_full | (tx_hold & (tx_cnt > tx_trig));
    assign rx_blk = (rx_cnt >= rx_trig) | (rx_to & rx_cnt != 7'd0)
                    | (rx_hold & rx_cnt != 7'd0);
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            tx_hold <= 1'b0;
            rx_hold <= 1'b0;
        end else begin
            tx_hold <= tx_blk;
            rx_hold <= rx_blk;
        end
    end
    assign TX_DMA_REQ_N = mode1 ? tx_blk : (tx_cnt != 7'd0);
    assign RX_DMA_REQ_N = mode1 ? ~rx_blk : (rx_cnt == 7'd0);

    // =====================================================
    // Read data, captured on the first cycle of a read
    logic [7:0] line_state_reg;
    uff_setup_t setup_rd;
    assign line_state_reg = {
        (rx_err_cnt != 7'd0),
        (tx_cnt == 7'd0) & ~TX_SHIFT_BUSY,
        (tx_cnt == 7'd0),
        rx_cnt != 7'd0 ? rx_mem[rx_rd][11:9] : 3'd0,
        overrun,
        (rx_cnt != 7'd0)
    };
    always_comb begin
        setup_rd = setup;
        setup_rd.tx_fifo_clear = 1'b0;
        setup_rd.rx_fifo_clear = 1'b0;
    end
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            AVS_READDATA <= 32'h0;
        end else if (AVS_READ & ~done) begin
            AVS_READDATA <= 32'h0;
            if (sel(AVS_ADDRESS, `UFF_OFF_DATA)) begin
                AVS_READDATA[7:0] <= rx_cnt != 7'd0 ?
                    rx_mem[rx_rd].data : 8'h00;
            end
            if (sel(AVS_ADDRESS, `UFF_OFF_MASK)) begin
                AVS_READDATA[3:0] <= irq_mask_reg;
            end
            if (sel(AVS_ADDRESS, `UFF_OFF_SETUP)) begin
                AVS_READDATA[7:0] <= setup_rd;
            end
            if (sel(AVS_ADDRESS, `UFF_OFF_CAUSE)) begin
                AVS_READDATA[7:0] <= {fifo_on, fifo_on, setup.deep,
                                      1'b0, cause};
            end
            if (sel(AVS_ADDRESS, `UFF_OFF_LINE)) begin
                AVS_READDATA[7:0] <= line_state_reg;
            end
            if (sel(AVS_ADDRESS, `UFF_OFF_TXTRIG)) begin
                AVS_READDATA[6:0] <= tx_trig;
            end
        end
    end

    // =====================================================
    // Checks
    AST_RX_IRQ_LEVEL: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        (fifo_on & irq_mask_reg[0]) |-> (rx_irq_i == (rx_cnt >= rx_trig)))
        else $error("rx irq not tied to trigger level");
    AST_CAUSE_RX: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        rx_irq_i |-> cause == `UFF_CAUSE_RXLVL)
        else $error("cause misses receive level");
    AST_DATA_READY: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        rx_in & ~rx_clr |=> line_state_reg[0])
        else $error("data ready not set after store");
    AST_TX_EMPTY: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        line_state_reg[6] |-> line_state_reg[5])
        else $error("bit 6 set without bit 5");
    AST_MODE0_TX: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        ~mode1 & tx_push & ~tx_clr |=> TX_DMA_REQ_N)
        else $error("tx ready still low after load");
    AST_MODE0_RX: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        ~mode1 |-> (RX_DMA_REQ_N == (rx_cnt == 7'd0)))
        else $error("mode 0 rx ready wrong");
    AST_MODE1_RX: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        mode1 & $past(mode1) & $fell(RX_DMA_REQ_N)
        |-> (rx_cnt >= rx_trig) | rx_to)
        else $error("rx ready fell without cause");
    AST_NO_OVERFILL: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        rx_cnt <= `UFF_DEPTH_DEEP)
        else $error("rx count past depth");
    AST_CLEAR_ONE: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        rx_clr |=> rx_cnt == 7'd0 && setup.rx_fifo_clear == 1'b0)
        else $error("rx clear took longer than one clock");
    AST_TX_CLEAR: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        tx_clr |=> tx_cnt == 7'd0 && setup.tx_fifo_clear == 1'b0)
        else $error("tx clear took longer than one clock");
    AST_IGNORE_OFF: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        setup_wr & ~wsetup.fifo_en |=> $stable(setup.dma_mode))
        else $error("setup changed with enable low");
    AST_WAIT_ONE: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        req & ~done |=> ~AVS_WAITREQUEST)
        else $error("bus answer late");
    AST_MODE1_TX_FULL: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        mode1 & tx_full |-> TX_DMA_REQ_N)
        else $error("tx ready low with full fifo");
    AST_MODE1_TX_TRIG: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        mode1 & ~tx_full & (tx_cnt <= tx_trig) |-> ~TX_DMA_REQ_N)
        else $error("tx ready high at trigger level");
    AST_TX_IRQ_BLOCK: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        mode1 & irq_mask_reg[1] |-> (TX_IRQ == (tx_cnt < tx_trig)))
        else $error("block mode tx irq wrong");
    AST_SINGLE_HOLD: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        ~fifo_on |-> (rx_cnt <= 7'd1) && (tx_cnt <= 7'd1))
        else $error("more than one byte held with fifos off");
endmodule

/* File: verif/uff_host_model.sv */
// Host side bus master model for the FIFO control block.
// Assumes one clock shared with the block and one access at a time.
`timescale 1ns/1ps
module uff_host_model #(
    parameter int ADDR_W = 5,
    parameter int WAIT_MAX = 40
) (
    input wire logic clk,
    output logic [ADDR_W-1:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    output logic hang
);
    // ==========================================================
    // Idle bus at time zero
    initial begin
        address = '0;
        {read, write, hang} = 3'h0;
        writedata = 32'h0;
    end

    // ==========================================================
    // One access; the request is held until waitrequest is sampled low,
    // so no slave latency is assumed. A stuck slave raises hang.
    task automatic access(input logic [ADDR_W-1:0] a, input logic rd,
                          input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        q = 32'h0;
        @(posedge clk);
        address <= a;
        read <= rd;
        write <= !rd;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < WAIT_MAX);
        q = readdata; // Sampled at the edge that ends the wait
        read <= 1'b0;
        write <= 1'b0;
        if (n >= WAIT_MAX) begin
            hang <= 1'b1;
        end
    endtask
endmodule

/* File: verif/uart_fifo_control_dma_ready_bench.sv */
// Self-checking bench for the FIFO control and DMA-ready block.
// Assumes the block answers each bus access after one wait cycle or more.
`timescale 1ns/1ps
`include "uff_consts.svh"
module uart_fifo_control_dma_ready_bench import uff_pkg::*;;
    logic clk, rst, rd_s, wr_s, waitreq, hang;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, q;
    logic rx_push, rx_timeout, tx_valid, tx_pop, tx_busy;
    uff_rx_word_t rx_word;
    logic [7:0] tx_data;
    logic rx_irq, tx_irq, tx_req_n, rx_req_n;
    int n_mismatch, check_count, seed, lvl;
    logic [7:0] exp_q[$];

    uff_top dut (.CORE_CLK(clk), .RESET(rst), .AVS_ADDRESS(addr),
        .AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdata),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .RX_PUSH(rx_push),
        .RX_WORD(rx_word), .RX_TIMEOUT(rx_timeout), .TX_VALID(tx_valid),
        .TX_DATA(tx_data), .TX_POP(tx_pop), .TX_SHIFT_BUSY(tx_busy),
        .RX_DATA_IRQ(rx_irq), .TX_IRQ(tx_irq), .TX_DMA_REQ_N(tx_req_n),
        .RX_DMA_REQ_N(rx_req_n));
    uff_host_model host (.clk(clk), .address(addr), .read(rd_s),
        .write(wr_s), .writedata(wdata), .readdata(rdata),
        .waitrequest(waitreq), .hang(hang));

    // ==========================================================
    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        host.access(a, 1'b1, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        host.access(a, 1'b0, d, q);
    endtask
    // Outputs are looked at mid-cycle, after the edge's updates landed
    task automatic settle();
        @(negedge clk);
    endtask
    // Back-to-back receive pushes; only the first keep bytes are stored
    task automatic push(input int n, input logic [2:0] err, input int keep);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            @(posedge clk);
            rx_push <= 1'b1;
            rx_word <= {err, 1'b0, d};
            if (i < keep) exp_q.push_back(d);
        end
        @(posedge clk);
        rx_push <= 1'b0;
    endtask
    task automatic pop_tx(input int n);
        repeat (n) begin
            @(posedge clk);
            tx_pop <= 1'b1;
        end
        @(posedge clk);
        tx_pop <= 1'b0;
    endtask
    // Receive trigger level for a depth bit and trigger code
    function automatic int trig(input logic deep, input logic [1:0] code);
        case ({deep, code})
            3'h0: return `UFF_TRIG_S0;
            3'h1: return `UFF_TRIG_S1;
            3'h2: return `UFF_TRIG_S2;
            3'h3: return `UFF_TRIG_S3;
            3'h4: return `UFF_TRIG_D0;
            3'h5: return `UFF_TRIG_D1;
            3'h6: return `UFF_TRIG_D2;
            default: return `UFF_TRIG_D3;
        endcase
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // A stuck bus access ends the run as a failure
    always @(posedge hang) begin
        n_mismatch++;
        complete_run();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {rst, rx_push, rx_timeout, tx_pop, tx_busy} = 5'h10;
        rx_word = '0;
        {n_mismatch, check_count} = 0;
        seed = 28420;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk({tx_req_n, rx_req_n, tx_valid, rx_irq, tx_irq}, 5'h08);
        rd(`UFF_OFF_SETUP, 32'h0);
        rd(`UFF_OFF_CAUSE, 32'h01);
        rd(`UFF_OFF_LINE, 32'h60);
        rd(5'h18, 32'h0);
        $display("reset test done");
        // Holding mode: second byte is dropped while the first waits
        wr(`UFF_OFF_DATA, 32'ha5);
        wr(`UFF_OFF_DATA, 32'h5a);
        settle();
        chk({tx_valid, tx_req_n, tx_data}, 10'h3a5);
        pop_tx(1);
        settle();
        chk({tx_valid, tx_req_n}, 2'h0);
        push(1, 3'h0, 1);
        settle();
        chk(rx_req_n, 1'b0);
        rd(`UFF_OFF_LINE, 32'h61);
        rd(`UFF_OFF_DATA, exp_q.pop_front());
        settle();
        chk(rx_req_n, 1'b1);
        $display("holding test done");
        // Every depth and trigger code
        wr(`UFF_OFF_MASK, 32'h1);
        for (int dp = 0; dp < 2; dp++) begin
            for (int c = 0; c < 4; c++) begin
                wr(`UFF_OFF_SETUP, {c[1:0], dp[0], 5'h07});
                exp_q.delete();
                lvl = trig(dp[0], c[1:0]);
                push(lvl - 1, 3'h0, lvl);
                settle();
                chk(rx_irq, 1'b0);
                push(1, 3'h0, 1);
                settle();
                chk(rx_irq, 1'b1);
                rd(`UFF_OFF_CAUSE, {26'h3, dp[0], 5'h04});
                rd(`UFF_OFF_DATA, exp_q.pop_front());
                settle();
                chk(rx_irq, 1'b0);
                rd(`UFF_OFF_CAUSE, {26'h3, dp[0], 5'h01});
            end
        end
        $display("trigger test done");
        // Filling past the trigger up to full, then one overrun
        wr(`UFF_OFF_SETUP, 32'hc7);
        exp_q.delete();
        push(17, 3'h0, 16);
        rd(`UFF_OFF_LINE, 32'h63);
        repeat (16) rd(`UFF_OFF_DATA, exp_q.pop_front());
        rd(`UFF_OFF_LINE, 32'h60);
        $display("full test done");
        // Polled mode status bits
        wr(`UFF_OFF_MASK, 32'h0);
        wr(`UFF_OFF_DATA, 32'h3c);
        rd(`UFF_OFF_LINE, 32'h0);
        @(posedge clk);
        tx_busy <= 1'b1;
        pop_tx(1);
        rd(`UFF_OFF_LINE, 32'h20);
        @(posedge clk);
        tx_busy <= 1'b0;
        rd(`UFF_OFF_LINE, 32'h60);
        for (int k = 0; k < 3; k++) begin
            push(1, 3'h1 << k, 1);
            rd(`UFF_OFF_LINE, {24'h0, 3'h7, 3'h1 << k, 2'h1});
            settle();
            chk({rx_irq, tx_irq}, 2'h0);
            rd(`UFF_OFF_DATA, exp_q.pop_front());
        end
        rd(`UFF_OFF_LINE, 32'h60);
        $display("polled test done");
        // Block mode transmit
        wr(`UFF_OFF_MASK, 32'h2);
        wr(`UFF_OFF_SETUP, 32'h0f);
        settle();
        chk({tx_req_n, tx_irq}, 2'h1);
        repeat (16) wr(`UFF_OFF_DATA, 32'($random(seed) & 8'hff));
        settle();
        chk({tx_req_n, tx_irq}, 2'h2);
        pop_tx(8);
        settle();
        chk({tx_req_n, tx_irq}, 2'h0);
        pop_tx(1);
        settle();
        chk(tx_irq, 1'b1);
        wr(`UFF_OFF_SETUP, 32'h0d);
        settle();
        chk(tx_valid, 1'b0);
        rd(`UFF_OFF_SETUP, 32'h09);
        $display("block transmit test done");
        // Block mode receive, trigger then time-out
        wr(`UFF_OFF_MASK, 32'h1);
        wr(`UFF_OFF_SETUP, 32'h4b);
        exp_q.delete();
        push(3, 3'h0, 3);
        settle();
        chk(rx_req_n, 1'b1);
        push(1, 3'h0, 1);
        settle();
        chk(rx_req_n, 1'b0);
        rd(`UFF_OFF_DATA, exp_q.pop_front());
        settle();
        chk(rx_req_n, 1'b0);
        repeat (3) rd(`UFF_OFF_DATA, exp_q.pop_front());
        settle();
        chk(rx_req_n, 1'b1);
        push(1, 3'h0, 1);
        settle();
        chk(rx_req_n, 1'b1);
        @(posedge clk);
        rx_timeout <= 1'b1;
        @(posedge clk);
        rx_timeout <= 1'b0;
        settle();
        chk({rx_req_n, rx_irq}, 2'h1);
        rd(`UFF_OFF_CAUSE, 32'hcc);
        rd(`UFF_OFF_DATA, exp_q.pop_front());
        $display("block receive test done");
        complete_run();
    end
endmodule
